// ==== pkg/adcc_pkg.sv ====
// adcc_pkg: constants and types of the converter control block
`default_nettype none
package adcc_pkg;
   // ==========================================================
   // register addresses and reset values
   localparam logic [7:0] ADCC_TIMING_ADDR  = 8'h00_EF;
   localparam logic [7:0] ADCC_CHMODE_ADDR  = 8'h00_D8;
   localparam logic [7:0] ADCC_TIMING_RST   = 8'h00_00;
   localparam logic [7:0] ADCC_CHMODE_RST   = 8'h00_00;
   // ==========================================================
   // timing/power register field positions
   localparam int ADCC_PWR_BIT   = 7;
   localparam int ADCC_EXTREF_BIT = 6;
   localparam int ADCC_DIV_HI    = 5;
   localparam int ADCC_DIV_LO    = 4;
   localparam int ADCC_ACQ_HI    = 3;
   localparam int ADCC_ACQ_LO    = 2;
   localparam int ADCC_TMR_BIT   = 1;
   localparam int ADCC_PIN_BIT   = 0;
   // ==========================================================
   // channel/mode register field positions
   localparam int ADCC_DONE_BIT  = 7;
   localparam int ADCC_DMA_BIT   = 6;
   localparam int ADCC_CONT_BIT  = 5;
   localparam int ADCC_SNGL_BIT  = 4;
   localparam int ADCC_CH_HI     = 3;
   localparam int ADCC_CH_LO     = 0;
   // ==========================================================
   // counts in converter clocks and channel codes
   localparam logic [4:0] ADCC_CONV_CLKS = 5'h0_11;
   localparam logic [3:0] ADCC_CH_TEMP   = 4'h8;
   localparam logic [3:0] ADCC_CH_DAC0   = 4'h9;
   localparam logic [3:0] ADCC_CH_DAC1   = 4'hA;
   localparam logic [3:0] ADCC_CH_AGND   = 4'hB;
   localparam logic [3:0] ADCC_CH_VREF   = 4'hC;
   localparam logic [3:0] ADCC_CH_STOP   = 4'hF;
   // ==========================================================
   // sequencer states, gray along idle-fetch-acquire-convert
   typedef enum logic [1:0] {
      ADCC_IDLE  = 2'b00,
      ADCC_FETCH = 2'b01,
      ADCC_ACQ   = 2'b11,
      ADCC_CONV  = 2'b10
   } adcc_state_t;
   // last count of the master clock divider for a select code
   function automatic logic [3:0] adcc_div_last(input logic [1:0] sel);
      unique case (sel)
         2'b00: adcc_div_last = 4'hF;
         2'b01: adcc_div_last = 4'h1;
         2'b10: adcc_div_last = 4'h3;
         2'b11: adcc_div_last = 4'h7;
      endcase
   endfunction
endpackage
`default_nettype wire

// ==== pkg/adcc_div_if.sv ====
// adcc_div_if: link between sequencer and converter clock divider
`timescale 1ns/1ps
`default_nettype none
interface adcc_div_if;
   logic [1:0] sel;
   logic       run;
   logic       tick;
   modport ctrl (output sel, output run, input tick);
   modport div  (input sel, input run, output tick);
endinterface
`default_nettype wire

// ==== core/adcc_clkdiv.sv ====
// adcc_clkdiv: divides the master clock into converter clock ticks
`timescale 1ns/1ps
`default_nettype none
module adcc_clkdiv
   import adcc_pkg::*;
(
   input  wire logic  mclk,
   input  wire logic  rst_n,
   input  wire logic  clk_en,
   adcc_div_if.div    dv
);
   typedef struct packed {
      logic [3:0] cnt;
      logic       tick;
   } adcc_div_st_t;

   adcc_div_st_t st_ff;
   adcc_div_st_t nxt_st;

   // count to the selected last value, one tick per wrap
   always_comb begin
      nxt_st = st_ff;
      nxt_st.tick = 1'b0;
      if (!dv.run) begin
         nxt_st.cnt = 4'h0;
      end else if (st_ff.cnt >= adcc_div_last(dv.sel)) begin
         nxt_st.cnt  = 4'h0;
         nxt_st.tick = 1'b1;
      end else begin
         nxt_st.cnt = st_ff.cnt + 4'h1;
      end
   end

   // state register, frozen while the clock enable is low
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff <= '0;
      end else if (clk_en) begin
         st_ff <= nxt_st;
      end
   end

   assign dv.tick = st_ff.tick;
endmodule
`default_nettype wire

// ==== core/adcc_ctrl.sv ====
// adcc_ctrl: converter sequencer with its two control registers
`timescale 1ns/1ps
`default_nettype none
module adcc_ctrl
   import adcc_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        arst_n,
   input  wire logic        clk_en,
   input  wire logic [7:0]  sfr_addr,
   input  wire logic        sfr_wr,
   input  wire logic [7:0]  sfr_wdata,
   input  wire logic        sfr_rd,
   output logic      [7:0]  sfr_rdata,
   input  wire logic        isr_vector_ack,
   input  wire logic        timer_overflow,
   input  wire logic        convert_start_n,
   input  wire logic        cal_busy,
   input  wire logic [11:0] sar_result,
   input  wire logic        dma_chan_valid,
   input  wire logic [3:0]  dma_chan_id,
   output logic             dma_chan_req,
   output logic             adc_power_on,
   output logic             external_reference_select,
   output logic             track,
   output logic             hold,
   output logic             conv_tick,
   output logic      [3:0]  conv_channel,
   output logic      [7:0]  result_high_byte,
   output logic      [7:0]  result_low_byte,
   output logic             result_valid,
   output logic             busy,
   output logic             ale_enable
);
   // ==========================================================
   // reset release through two flops
   logic [1:0] rst_sync_ff;

   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rst_sync_ff <= 2'b00;
      end else begin
         rst_sync_ff <= {rst_sync_ff[0], 1'b1};
      end
   end

   logic rst_n;
   assign rst_n = rst_sync_ff[1];

   // ==========================================================
   // all state of the sequencer
   typedef struct packed {
      adcc_state_t st;
      logic [7:0]  tim;       // timing/power register
      logic [7:0]  chm;       // channel/mode register
      logic [2:0]  acq_cnt;
      logic [4:0]  conv_cnt;
      logic [3:0]  chan;
      logic        pin_q;
      logic        dma_run;
      logic        dma_req;
      logic        in_dma;    // current conversion belongs to DMA
      logic [7:0]  res_hi;
      logic [7:0]  res_lo;
      logic        res_vld;
      logic [7:0]  rdata;
   } adcc_st_t;

   adcc_st_t st_ff;
   adcc_st_t nxt_st;

   adcc_div_if div_if ();

   // divider runs whenever the converter is powered
   assign div_if.sel = {st_ff.tim[ADCC_DIV_HI], st_ff.tim[ADCC_DIV_LO]};
   assign div_if.run = st_ff.tim[ADCC_PWR_BIT];

   adcc_clkdiv i_adcc_clkdiv (
      .mclk   (mclk),
      .rst_n  (rst_n),
      .clk_en (clk_en),
      .dv     (div_if.div)
   );

   // ==========================================================
   // decoded controls
   logic       pwr;
   logic       tick;
   logic       wr_tim;
   logic       wr_chm;
   logic       pin_fall;
   logic       trig;
   logic [2:0] acq_last;
   logic       conv_end;
   logic       dma_on;

   assign pwr      = st_ff.tim[ADCC_PWR_BIT];
   assign tick     = div_if.tick;
   assign wr_tim   = sfr_wr && (sfr_addr == ADCC_TIMING_ADDR);
   assign wr_chm   = sfr_wr && (sfr_addr == ADCC_CHMODE_ADDR);
   assign dma_on   = st_ff.chm[ADCC_DMA_BIT];
   // pin input is synchronous, so one flop finds the falling edge
   assign pin_fall = st_ff.pin_q && !convert_start_n;
   // any enabled start source
   assign trig = st_ff.chm[ADCC_SNGL_BIT]
              || st_ff.chm[ADCC_CONT_BIT]
              || (st_ff.tim[ADCC_TMR_BIT] && timer_overflow)
              || (st_ff.tim[ADCC_PIN_BIT] && pin_fall);
   // code n gives n+1 converter clocks of acquisition
   assign acq_last = {1'b0, st_ff.tim[ADCC_ACQ_HI],
                      st_ff.tim[ADCC_ACQ_LO]};
   assign conv_end = (st_ff.st == ADCC_CONV) && tick
                  && (st_ff.conv_cnt == ADCC_CONV_CLKS - 5'h01);

   // ==========================================================
   // sequencer and register update
   always_comb begin
      logic set_done;
      logic clr_sngl;
      logic clr_dma;
      set_done = 1'b0;
      clr_sngl = 1'b0;
      clr_dma  = 1'b0;
      nxt_st = st_ff;
      nxt_st.pin_q   = convert_start_n;
      nxt_st.dma_req = 1'b0;
      nxt_st.res_vld = 1'b0;

      unique case (st_ff.st)
         ADCC_IDLE: begin
            if (pwr && trig) begin
               nxt_st.acq_cnt = 3'h0;
               if (dma_on) begin
                  // first trigger after setting the bit launches DMA
                  nxt_st.st      = ADCC_FETCH;
                  nxt_st.dma_run = 1'b1;
                  nxt_st.dma_req = 1'b1;
               end else begin
                  nxt_st.st     = ADCC_ACQ;
                  nxt_st.in_dma = 1'b0;
                  nxt_st.chan   = st_ff.chm[ADCC_CH_HI:ADCC_CH_LO];
               end
            end
         end
         ADCC_FETCH: begin
            // wait for the next channel code from the capture table
            if (dma_chan_valid) begin
               if (dma_chan_id == ADCC_CH_STOP) begin
                  nxt_st.st      = ADCC_IDLE;
                  nxt_st.dma_run = 1'b0;
                  clr_dma        = 1'b1;
                  set_done       = 1'b1;
               end else begin
                  nxt_st.st      = ADCC_ACQ;
                  nxt_st.in_dma  = 1'b1;
                  nxt_st.chan    = dma_chan_id;
                  nxt_st.acq_cnt = 3'h0;
               end
            end
         end
         ADCC_ACQ: begin
            if (tick) begin
               if (st_ff.acq_cnt == acq_last) begin
                  nxt_st.st       = ADCC_CONV;
                  nxt_st.conv_cnt = 5'h00;
               end else begin
                  nxt_st.acq_cnt = st_ff.acq_cnt + 3'h1;
               end
            end
         end
         ADCC_CONV: begin
            if (conv_end) begin
               // channel code rides in the top nibble of the result
               nxt_st.res_hi  = {st_ff.chan, sar_result[11:8]};
               nxt_st.res_lo  = sar_result[7:0];
               nxt_st.res_vld = 1'b1;
               nxt_st.acq_cnt = 3'h0;
               if (st_ff.in_dma) begin
                  // capture keeps going until the stop code
                  nxt_st.st      = ADCC_FETCH;
                  nxt_st.dma_req = 1'b1;
               end else begin
                  set_done = 1'b1;
                  clr_sngl = 1'b1;
                  if (st_ff.chm[ADCC_CONT_BIT]) begin
                     nxt_st.st = ADCC_ACQ;
                     nxt_st.chan = st_ff.chm[ADCC_CH_HI:ADCC_CH_LO];
                  end else begin
                     nxt_st.st = ADCC_IDLE;
                  end
               end
            end else if (tick) begin
               nxt_st.conv_cnt = st_ff.conv_cnt + 5'h01;
            end
         end
      endcase

      // powering down abandons any conversion in flight
      if (!pwr) begin
         nxt_st.st      = ADCC_IDLE;
         nxt_st.dma_run = 1'b0;
         nxt_st.dma_req = 1'b0;
         nxt_st.res_vld = 1'b0;
         set_done       = 1'b0;
         clr_sngl       = 1'b0;
         clr_dma        = 1'b0;
      end

      // software writes, then hardware clears, then hardware sets
      if (wr_tim) begin
         nxt_st.tim = sfr_wdata;
      end
      if (wr_chm) begin
         nxt_st.chm = sfr_wdata;
      end
      if (clr_sngl && !(wr_chm && sfr_wdata[ADCC_SNGL_BIT])) begin
         nxt_st.chm[ADCC_SNGL_BIT] = 1'b0;
      end
      if (clr_dma && !(wr_chm && sfr_wdata[ADCC_DMA_BIT])) begin
         nxt_st.chm[ADCC_DMA_BIT] = 1'b0;
      end
      if (isr_vector_ack) begin
         nxt_st.chm[ADCC_DONE_BIT] = 1'b0;
      end
      // a completion in the clearing cycle is kept
      if (set_done) begin
         nxt_st.chm[ADCC_DONE_BIT] = 1'b1;
      end

      // read data is registered, one cycle after the read strobe
      if (sfr_rd) begin
         if (sfr_addr == ADCC_TIMING_ADDR) begin
            nxt_st.rdata = st_ff.tim;
         end else if (sfr_addr == ADCC_CHMODE_ADDR) begin
            nxt_st.rdata = st_ff.chm;
         end else begin
            nxt_st.rdata = 8'h00;
         end
      end
   end

   // ==========================================================
   // the single state register, frozen by the clock enable
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_ff          <= '0;
         st_ff.st       <= ADCC_IDLE;
         st_ff.tim      <= ADCC_TIMING_RST;
         st_ff.chm      <= ADCC_CHMODE_RST;
         st_ff.pin_q    <= 1'b1;
      end else if (clk_en) begin
         st_ff <= nxt_st;
      end
   end

   // ==========================================================
   // outputs
   assign sfr_rdata                 = st_ff.rdata;
   assign adc_power_on              = st_ff.tim[ADCC_PWR_BIT];
   assign external_reference_select = st_ff.tim[ADCC_EXTREF_BIT];
   assign track                     = (st_ff.st == ADCC_ACQ);
   assign hold                      = (st_ff.st == ADCC_CONV);
   assign conv_tick                 = tick;
   // internal sources sit above code 7; the analog mux decodes them
   assign conv_channel              = st_ff.chan;
   assign result_high_byte          = st_ff.res_hi;
   assign result_low_byte           = st_ff.res_lo;
   assign result_valid              = st_ff.res_vld;
   assign dma_chan_req              = st_ff.dma_req;
   // busy covers acquisition and conversion, not table fetches
   assign busy = track || hold || cal_busy;
   // address latch held off from DMA set until capture starts
   assign ale_enable = !(dma_on && !st_ff.dma_run);
endmodule
`default_nettype wire

// ==== tb/adcc_far_side.sv ====
// adcc_far_side: capture table memory and SAR data source beside the block
`timescale 1ns/1ps
`default_nettype none
module adcc_far_side
   import adcc_pkg::*;
(
   input  wire logic        mclk,
   input  wire logic        arst_n,
   input  wire logic [3:0]  lag,
   input  wire logic        dma_chan_req,
   input  wire logic [3:0]  conv_channel,
   output logic             dma_chan_valid,
   output logic      [3:0]  dma_chan_id,
   output logic      [11:0] sar_result
);
   // ======================================================
   // table: two channels, then the stop marker
   localparam logic [11:0] TBL = {ADCC_CH_STOP, 4'h5, 4'h2};
   logic [1:0] idx_ff;
   logic [3:0] wait_ff;
   logic       pend_ff;
   // data tied to the channel so a wrong mux shows in the result
   assign sar_result = {conv_channel, conv_channel ^ 4'h5, 4'hC};
   // answer each request after lag cycles; the id goes stale after use
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         idx_ff <= 2'd0;
         wait_ff <= 4'h0;
         pend_ff <= 1'b0;
         dma_chan_valid <= 1'b0;
         dma_chan_id <= 4'h0;
      end else begin
         dma_chan_valid <= 1'b0;
         if (dma_chan_valid) dma_chan_id <= ~dma_chan_id;
         if (dma_chan_req) begin
            pend_ff <= 1'b1;
            wait_ff <= lag;
         end else if (pend_ff && wait_ff == 4'h0) begin
            pend_ff <= 1'b0;
            dma_chan_valid <= 1'b1;
            dma_chan_id <= TBL[{idx_ff, 2'b00} +: 4];
            idx_ff <= idx_ff + 2'd1;
         end else if (pend_ff) begin
            wait_ff <= wait_ff - 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ==== tb/adcc_ctrl_asserts.sv ====
// adcc_ctrl_asserts: port-level timing checks of the converter control
`timescale 1ns/1ps
`default_nettype none
module adcc_ctrl_asserts
   import adcc_pkg::*;
(
   input wire logic       mclk,
   input wire logic       arst_n,
   input wire logic       clk_en,
   input wire logic [7:0] sfr_addr,
   input wire logic       sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic       timer_overflow,
   input wire logic       convert_start_n,
   input wire logic       cal_busy,
   input wire logic       dma_chan_req,
   input wire logic       adc_power_on,
   input wire logic       track,
   input wire logic       hold,
   input wire logic       conv_tick,
   input wire logic [3:0] conv_channel,
   input wire logic [7:0] result_high_byte,
   input wire logic       result_valid,
   input wire logic       busy,
   input wire logic       ale_enable
);
   logic [7:0] tm_ff;
   logic [4:0] acq_ff;
   logic [4:0] cnv_ff;
   logic       idle;
   // ======================================================
   // timing register shadow and tick counts per phase
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         tm_ff <= ADCC_TIMING_RST;
         acq_ff <= 5'h00;
         cnv_ff <= 5'h00;
      end else begin
         if (clk_en && sfr_wr && sfr_addr == ADCC_TIMING_ADDR) begin
            tm_ff <= sfr_wdata;
         end
         acq_ff <= track ? acq_ff + {4'h0, conv_tick} : 5'h00;
         cnv_ff <= hold ? cnv_ff + {4'h0, conv_tick} : 5'h00;
      end
   end
   // ale low means capture is armed, where a trigger fetches first
   assign idle = !track && !hold && ale_enable && tm_ff[ADCC_PWR_BIT];
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!arst_n);
   // ======================================================
   AST_PWR_OFF: assert property (!adc_power_on [*2] |-> !track && !hold)
      else $error("converter active while powered down");
   AST_ACQ_LEN: assert property ($rose(hold) |-> acq_ff ==
      {3'b000, tm_ff[ADCC_ACQ_HI:ADCC_ACQ_LO]} + 5'h01)
      else $error("acquisition tick count wrong");
   AST_CONV_LEN: assert property (result_valid |->
      $fell(hold) && cnv_ff == ADCC_CONV_CLKS)
      else $error("conversion tick count wrong");
   AST_TMR_START: assert property (timer_overflow && idle &&
      tm_ff[ADCC_TMR_BIT] |-> ##[1:3] track)
      else $error("timer trigger ignored");
   AST_PIN_START: assert property ($fell(convert_start_n) && idle &&
      tm_ff[ADCC_PIN_BIT] |-> ##[1:4] track)
      else $error("pin trigger ignored");
   AST_RES_CHAN: assert property (result_valid |->
      result_high_byte[7:4] == conv_channel)
      else $error("result channel nibble wrong");
   AST_BUSY: assert property (busy == (track || hold || cal_busy))
      else $error("busy does not follow activity");
   AST_ONE_PHASE: assert property (!(track && hold))
      else $error("track and hold together");
   AST_REQ_PULSE: assert property (dma_chan_req |=> !dma_chan_req)
      else $error("table request longer than a cycle");
   AST_ALE_STOP: assert property ($fell(ale_enable) |->
      $past(sfr_wr && sfr_addr == ADCC_CHMODE_ADDR && sfr_wdata[6]))
      else $error("ale stopped without capture arm");
   cover property (result_valid);
   cover property ($rose(hold) && tm_ff[3:2] == 2'b11);
   cover property (dma_chan_req);
   cover property ($fell(ale_enable));
endmodule
bind adcc_ctrl adcc_ctrl_asserts i_adcc_ctrl_asserts (.mclk, .arst_n,
   .clk_en, .sfr_addr, .sfr_wr, .sfr_wdata, .timer_overflow,
   .convert_start_n, .cal_busy, .dma_chan_req, .adc_power_on, .track,
   .hold, .conv_tick, .conv_channel, .result_high_byte, .result_valid,
   .busy, .ale_enable);
`default_nettype wire

// ==== tb/adcc_ctrl_bench.sv ====
// adcc_ctrl_bench: register-level tests of the converter control block
`timescale 1ns/1ps
`default_nettype none
module adcc_ctrl_bench
   import adcc_pkg::*;
;
   logic        mclk, arst_n, clk_en, sfr_wr, sfr_rd, isr_vector_ack;
   logic        timer_overflow, convert_start_n, cal_busy, dma_chan_valid;
   logic        dma_chan_req, adc_power_on, external_reference_select;
   logic        track, hold, conv_tick, result_valid, busy, ale_enable;
   logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, result_high_byte;
   logic [7:0]  result_low_byte, d;
   logic [3:0]  dma_chan_id, conv_channel, lag;
   logic [11:0] sar_result;
   // internal sources assume a long enough acquisition and a live buffer
   logic [3:0]  chs [4] = '{4'h3, ADCC_CH_TEMP, ADCC_CH_DAC0, ADCC_CH_VREF};
   int          gaps [4] = '{16, 2, 4, 8};
   int          failures, comparisons, i, n;
   adcc_ctrl i_adcc_ctrl (.mclk, .arst_n, .clk_en, .sfr_addr, .sfr_wr,
      .sfr_wdata, .sfr_rd, .sfr_rdata, .isr_vector_ack, .timer_overflow,
      .convert_start_n, .cal_busy, .sar_result, .dma_chan_valid,
      .dma_chan_id, .dma_chan_req, .adc_power_on, .external_reference_select,
      .track, .hold, .conv_tick, .conv_channel, .result_high_byte,
      .result_low_byte, .result_valid, .busy, .ale_enable);
   adcc_far_side i_adcc_far_side (.mclk, .arst_n, .lag, .dma_chan_req,
      .conv_channel, .dma_chan_valid, .dma_chan_id, .sar_result);
   // ======================================================
   // compare, register access and waiting helpers
   task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                      input string what);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("[ERR] %0t %s: got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(negedge mclk);
      sfr_addr = a;
      sfr_wdata = v;
      sfr_wr = 1'b1;
      @(negedge mclk);
      sfr_wr = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(negedge mclk);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge mclk);
      sfr_rd = 1'b0;
      v = sfr_rdata;
   endtask
   task automatic wait_res(input logic [3:0] ch);
      int k = 0;
      do begin
         @(negedge mclk);
         k++;
      end while (result_valid !== 1'b1 && k < 3000);
      if (k >= 3000) begin
         failures++;
         $display("[ERR] %0t no result", $time);
         close_out();
      end
      chk(result_high_byte, {ch, ch}, "high byte");
      chk(result_low_byte, {ch ^ 4'h5, 4'hC}, "low byte");
   endtask
   // cycles between two converter ticks
   task automatic tick_gap(input int exp);
      int k = 0;
      while (conv_tick !== 1'b1 && k < 100) begin
         @(negedge mclk);
         k++;
      end
      @(negedge mclk);
      k = 1;
      while (conv_tick !== 1'b1 && k < 100) begin
         @(negedge mclk);
         k++;
      end
      chk(k[7:0], exp[7:0], "tick gap");
   endtask
   task automatic close_out();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // ======================================================
   initial begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end
   // ======================================================
   initial begin
      {arst_n, sfr_wr, sfr_rd, isr_vector_ack, timer_overflow} = 5'h00;
      {cal_busy, sfr_addr, sfr_wdata, lag} = 21'h0_0000;
      clk_en = 1'b1;
      convert_start_n = 1'b1;
      failures = 0;
      comparisons = 0;
      repeat (5) @(negedge mclk);
      arst_n = 1'b1;
      repeat (3) @(negedge mclk);
      rd(ADCC_TIMING_ADDR, d);
      chk(d, ADCC_TIMING_RST, "timing reset");
      rd(ADCC_CHMODE_ADDR, d);
      chk(d, ADCC_CHMODE_RST, "mode reset");
      rd(8'h55, d);
      chk(d, 8'h00, "unmapped read");
      wr(ADCC_TIMING_ADDR, 8'hC5);
      rd(ADCC_TIMING_ADDR, d);
      chk(d, 8'hC5, "timing readback");
      chk({6'h00, adc_power_on, external_reference_select}, 8'h03, "pwr");
      wr(ADCC_TIMING_ADDR, 8'h00);
      chk({6'h00, adc_power_on, external_reference_select}, 8'h00, "pwr");
      $display("test registers done");
      // every divider and acquisition code, single starts
      for (i = 0; i < 4; i++) begin
         wr(ADCC_TIMING_ADDR, {2'b10, i[1:0], i[1:0], 2'b00});
         wr(ADCC_CHMODE_ADDR, {4'h1, chs[i]});
         tick_gap(gaps[i]);
         chk({7'h00, busy}, 8'h01, "busy");
         wait_res(chs[i]);
         rd(ADCC_CHMODE_ADDR, d);
         chk(d, {4'h8, chs[i]}, "done set");
         if (i[0]) begin
            @(negedge mclk);
            isr_vector_ack = 1'b1;
            @(negedge mclk);
            isr_vector_ack = 1'b0;
         end else begin
            wr(ADCC_CHMODE_ADDR, {4'h0, chs[i]});
         end
         rd(ADCC_CHMODE_ADDR, d);
         chk(d, {4'h0, chs[i]}, "done cleared");
      end
      $display("test single done");
      // timer trigger off then on, then pin trigger
      for (i = 0; i < 2; i++) begin
         wr(ADCC_TIMING_ADDR, {6'h24, i[0], 1'b0});
         @(negedge mclk);
         timer_overflow = 1'b1;
         @(negedge mclk);
         timer_overflow = 1'b0;
         repeat (4) @(negedge mclk);
         chk({7'h00, track || hold}, {7'h00, i[0]}, "timer start");
      end
      wait_res(ADCC_CH_VREF);
      wr(ADCC_TIMING_ADDR, 8'h91);
      @(negedge mclk);
      convert_start_n = 1'b0;
      repeat (3) @(negedge mclk);
      convert_start_n = 1'b1;
      wait_res(ADCC_CH_VREF);
      $display("test triggers done");
      // continuous: back to back, then stop after the running one
      wr(ADCC_CHMODE_ADDR, 8'h21);
      wait_res(4'h1);
      wait_res(4'h1);
      wr(ADCC_CHMODE_ADDR, 8'h01);
      wait_res(4'h1);
      n = 0;
      repeat (60) begin
         @(negedge mclk);
         if (track !== 1'b0) n++;
      end
      chk(n[7:0], 8'h00, "stays idle");
      cal_busy = 1'b1;
      @(negedge mclk);
      chk({7'h00, busy}, 8'h01, "cal busy");
      cal_busy = 1'b0;
      $display("test continuous done");
      // power down in mid conversion aborts with no result
      wr(ADCC_CHMODE_ADDR, 8'h11);
      repeat (2) @(negedge mclk);
      chk({7'h00, track || hold}, 8'h01, "started");
      wr(ADCC_TIMING_ADDR, 8'h11);
      n = 0;
      repeat (80) begin
         @(negedge mclk);
         if (result_valid !== 1'b0) n++;
      end
      chk(n[7:0], 8'h00, "aborted");
      rd(ADCC_CHMODE_ADDR, d);
      chk(d & 8'h80, 8'h00, "no flag");
      wr(ADCC_CHMODE_ADDR, 8'h00);
      $display("test abort done");
      // table capture started by timer: slow then prompt far side
      lag = 4'h3;
      wr(ADCC_TIMING_ADDR, 8'h92);
      wr(ADCC_CHMODE_ADDR, 8'h40);
      chk({7'h00, ale_enable}, 8'h00, "ale stopped");
      @(negedge mclk);
      timer_overflow = 1'b1;
      @(negedge mclk);
      timer_overflow = 1'b0;
      wait_res(4'h2);
      lag = 4'h0;
      chk({7'h00, ale_enable}, 8'h01, "ale resumed");
      wait_res(4'h5);
      n = 0;
      d = 8'h00;
      while (d[7] !== 1'b1 && n < 20) begin
         rd(ADCC_CHMODE_ADDR, d);
         n++;
      end
      chk(d & 8'hC0, 8'h80, "capture end");
      chk({7'h00, ale_enable}, 8'h01, "ale after");
      $display("test capture done");
      close_out();
   end
endmodule
`default_nettype wire
